// [pkg/cps_pkg.sv]
// Shared constants and types of the card presence supervisor.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package cps_pkg;

    // ****************************************************************
    // Time base
    // ****************************************************************
    localparam longint unsigned CLK_HZ = 64'd25_000_000;
    // Longest quiet time allowed on the card interface during a call.
    localparam longint unsigned INACT_MAX_S = 64'd30;
    // Quiet time after which the presence query is raised; the margin
    // leaves room for a busy interface and the card's reply.
    localparam longint unsigned ASK_S = 64'd25;
    // Longest time from a query, or a bad reply, to the end of the call.
    localparam longint unsigned END_MAX_S = 64'd5;
    // Cycles kept back from the end deadline for the end pulse itself.
    localparam longint unsigned END_MARGIN_CYC = 64'd2;

    localparam int unsigned TMR_W = 30;
    localparam longint unsigned ASK_CYC_L = ASK_S * CLK_HZ;
    localparam longint unsigned RSP_CYC_L = END_MAX_S * CLK_HZ - END_MARGIN_CYC;
    localparam logic [TMR_W-1:0] ASK_CYC = ASK_CYC_L[TMR_W-1:0];
    localparam logic [TMR_W-1:0] RSP_CYC = RSP_CYC_L[TMR_W-1:0];

    // ****************************************************************
    // Field widths and sync depth
    // ****************************************************************
    localparam int unsigned DIR_W = 16;
    localparam int unsigned ID_W = 4;
    localparam int unsigned SYNC_N = 3;

    // ****************************************************************
    // Supervisor states, one-hot
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_WATCH = 5'h02,
        ST_ASK   = 5'h04,
        ST_WAIT  = 5'h08,
        ST_END   = 5'h10
    } cps_state_t;

    typedef struct packed {
        cps_state_t st;
        logic [SYNC_N-1:0] rm_sync;
        logic removed;
        logic [DIR_W-1:0] ref_dir;
        logic ref_ok;
        logic req;
        logic end_cs;
        logic end_pd;
        logic [ID_W-1:0] bearer_id;
    } cps_sup_t;

endpackage

// [pkg/cps_tmr_if.sv]
// Control and status lines between the supervisor and one interval timer.
// Assumes both ends run on the same system clock.
interface cps_tmr_if;
    logic restart;
    logic run;
    logic hit;

    modport ctl (output restart, output run, input hit);
    modport tmr (input restart, input run, output hit);
endinterface

// [src/cps_timer.sv]
// Interval timer: counts cycles while run is high and flags a limit.
// Assumes restart and run come from logic on the same clock.
module cps_timer #(
    parameter int unsigned W = cps_pkg::TMR_W,
    parameter logic [W-1:0] LIMIT = '1
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Control from the supervisor.
    cps_tmr_if.tmr t
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic hit;
    } cps_tmr_t;

    cps_tmr_t q;
    cps_tmr_t d;

    // ****************************************************************
    // Counting
    // ****************************************************************
    // The count holds at LIMIT - 1 so the flag stays until cleared.
    always_comb begin
        d = q;
        if (t.restart || !t.run) begin
            d.cnt = '0;
            d.hit = 1'b0;
        end else if (q.cnt == LIMIT - 1'b1) begin
            d.hit = 1'b1;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    // Register the whole state.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign t.hit = q.hit;

    restart_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
        t.restart |=> !t.hit) else $error("Timer flag survived a restart.");

endmodule

// [src/cps_supervisor.sv]
// Card presence supervisor: queries the card during calls and ends them on loss.
// Assumes call, exchange and reply signals come from logic on clk_sys; only the
// card removal switch is asynchronous.
//
// Behaviour
// - Query card before 30 s quiet during calls.
// - Quiet timer restarts at exchange end, query.
// - No reply data ends call within 5 s.
// - Changed directory in reply ends call promptly.
// - Circuit call or packet context counts as call.
// - Packet context failure tears down its bearer.
// - Removal switch also ends calls alongside queries.
module cps_supervisor #(
    parameter logic [cps_pkg::TMR_W-1:0] ASK_CYC = cps_pkg::ASK_CYC,
    parameter logic [cps_pkg::TMR_W-1:0] RSP_CYC = cps_pkg::RSP_CYC
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Call and bearer control.
    input wire logic cs_active,
    input wire logic pdp_active,
    input wire logic [cps_pkg::ID_W-1:0] ctx_id,
    output logic end_cs_q,
    output logic end_pd_q,
    output logic [cps_pkg::ID_W-1:0] bearer_id_q,
    // Card interface controller.
    input wire logic xfer_done,
    input wire logic dir_sel_valid,
    input wire logic [cps_pkg::DIR_W-1:0] dir_sel,
    output logic status_req_q,
    input wire logic status_sent,
    input wire logic rsp_valid,
    input wire logic rsp_nodata,
    input wire logic [cps_pkg::DIR_W-1:0] rsp_dir,
    // Mechanical removal switch.
    input wire logic card_out,
    output logic card_gone_q
);

    cps_pkg::cps_sup_t q;
    cps_pkg::cps_sup_t d;
    logic call;
    logic fail;

    cps_tmr_if quiet_if ();
    cps_tmr_if rsp_if ();

    // ****************************************************************
    // Timers
    // ****************************************************************
    // Quiet time counts only while watching a call; any leave clears it.
    assign quiet_if.run = (q.st == cps_pkg::ST_WATCH);
    assign quiet_if.restart = xfer_done || status_sent;
    // The reply deadline runs from the moment the query left.
    assign rsp_if.run = (q.st == cps_pkg::ST_WAIT);
    assign rsp_if.restart = status_sent;

    cps_timer #(
        .W(cps_pkg::TMR_W),
        .LIMIT(ASK_CYC)
    ) u_quiet (
        .clk_sys(clk_sys),
        .rst(rst),
        .t(quiet_if.tmr)
    );

    cps_timer #(
        .W(cps_pkg::TMR_W),
        .LIMIT(RSP_CYC)
    ) u_rsp (
        .clk_sys(clk_sys),
        .rst(rst),
        .t(rsp_if.tmr)
    );

    // ****************************************************************
    // Supervision sequence
    // ****************************************************************
    assign call = cs_active || pdp_active;

    // Next state. A failure in any watching state jumps to the end state,
    // which waits for the call side to drop before supervising again.
    always_comb begin
        d = q;
        fail = 1'b0;
        // The first sync stage feeds only the second one.
        d.rm_sync = {q.rm_sync[cps_pkg::SYNC_N-2:0], card_out};
        if (q.rm_sync[cps_pkg::SYNC_N-2] == q.rm_sync[cps_pkg::SYNC_N-1]) begin
            d.removed = q.rm_sync[cps_pkg::SYNC_N-1];
        end
        d.end_cs = 1'b0;
        d.end_pd = 1'b0;
        // A selection by a command sets the directory to compare against.
        if (dir_sel_valid) begin
            d.ref_dir = dir_sel;
            d.ref_ok = 1'b1;
        end
        case (q.st)
            cps_pkg::ST_IDLE: begin
                if (call) begin
                    d.st = cps_pkg::ST_WATCH;
                end
            end
            cps_pkg::ST_WATCH: begin
                if (!call) begin
                    d.st = cps_pkg::ST_IDLE;
                end else if (q.removed) begin
                    fail = 1'b1;
                end else if (quiet_if.hit) begin
                    d.st = cps_pkg::ST_ASK;
                end
            end
            cps_pkg::ST_ASK: begin
                if (!call) begin
                    d.st = cps_pkg::ST_IDLE;
                end else if (q.removed) begin
                    fail = 1'b1;
                end else if (status_sent) begin
                    d.st = cps_pkg::ST_WAIT;
                end
            end
            cps_pkg::ST_WAIT: begin
                if (!call) begin
                    d.st = cps_pkg::ST_IDLE;
                end else if (q.removed) begin
                    fail = 1'b1;
                end else if (rsp_valid) begin
                    if (rsp_nodata) begin
                        fail = 1'b1;
                    end else if (q.ref_ok && (rsp_dir != q.ref_dir)) begin
                        fail = 1'b1;
                    end else begin
                        d.st = cps_pkg::ST_WATCH;
                        d.ref_dir = rsp_dir;
                        d.ref_ok = 1'b1;
                    end
                end else if (rsp_if.hit) begin
                    fail = 1'b1;
                end
            end
            cps_pkg::ST_END: begin
                if (!call) begin
                    d.st = cps_pkg::ST_IDLE;
                end
            end
            default: begin
                d.st = cps_pkg::ST_IDLE;
            end
        endcase
        // Ending both sides at once keeps a mixed call from half-surviving.
        if (fail) begin
            d.st = cps_pkg::ST_END;
            d.end_cs = cs_active;
            d.end_pd = pdp_active;
            d.bearer_id = ctx_id;
        end
        d.req = (d.st == cps_pkg::ST_ASK);
    end

    // Register the whole state.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '{st: cps_pkg::ST_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign end_cs_q = q.end_cs;
    assign end_pd_q = q.end_pd;
    assign bearer_id_q = q.bearer_id;
    assign status_req_q = q.req;
    assign card_gone_q = q.removed;

    // ****************************************************************
    // Checks
    // ****************************************************************
    quiet_query_a: assert property (@(posedge clk_sys) disable iff (rst)
        (q.st == cps_pkg::ST_WATCH) && call && !q.removed && quiet_if.hit
        |=> status_req_q) else $error("Query not raised at quiet limit.");

    quiet_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
        (status_sent || xfer_done) && (q.st == cps_pkg::ST_WATCH)
        |=> !quiet_if.hit) else $error("Quiet timer not restarted.");

    nodata_end_a: assert property (@(posedge clk_sys) disable iff (rst)
        (q.st == cps_pkg::ST_WAIT) && call && rsp_valid && rsp_nodata
        |=> (q.st == cps_pkg::ST_END) && (end_cs_q || end_pd_q))
        else $error("Empty reply did not end the call.");

    late_reply_a: assert property (@(posedge clk_sys) disable iff (rst)
        (q.st == cps_pkg::ST_WAIT) && call && !rsp_valid && rsp_if.hit
        |=> end_cs_q || end_pd_q) else $error("Missing reply did not end the call.");

    dir_change_a: assert property (@(posedge clk_sys) disable iff (rst)
        (q.st == cps_pkg::ST_WAIT) && call && !q.removed && rsp_valid && !rsp_nodata
        && q.ref_ok && (rsp_dir != q.ref_dir) && !dir_sel_valid
        |=> (q.st == cps_pkg::ST_END) ##1 (q.st != cps_pkg::ST_WATCH))
        else $error("Changed directory did not end the call.");

    call_start_a: assert property (@(posedge clk_sys) disable iff (rst)
        (q.st == cps_pkg::ST_IDLE) && (cs_active || pdp_active)
        |=> (q.st == cps_pkg::ST_WATCH)) else $error("Call not supervised.");

    bearer_match_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(end_pd_q) |-> (bearer_id_q == $past(ctx_id)) && $past(pdp_active))
        else $error("Wrong bearer torn down.");

    removal_end_a: assert property (@(posedge clk_sys) disable iff (rst)
        q.removed && call && (q.st == cps_pkg::ST_WATCH)
        |=> (end_cs_q || end_pd_q) ##1 !(end_cs_q || end_pd_q))
        else $error("Removal did not end the call once.");

    idle_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
        !call |=> !status_req_q && !end_cs_q && !end_pd_q)
        else $error("Activity without a call.");

endmodule

// [bench/cps_card_model.sv]
// Model of the card and its interface controller as the supervisor sees them.
// Assumes the bench clock; all outputs change just after falling edges.
module cps_card_model (
    // Clock.
    input wire logic clk_sys,
    // Query side of the supervisor.
    input wire logic status_req_q,
    input wire logic [1:0] mode,
    input wire logic [15:0] good_dir,
    output logic status_sent,
    output logic rsp_valid,
    output logic rsp_nodata,
    output logic [15:0] rsp_dir
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pat;
    // ****************************************************************
    // Query service
    // ****************************************************************
    // Mode 0 answers well, 1 without data, 2 with another directory, 3 never.
    // Reply lines churn between replies so a stale value never matches.
    initial begin
        pat = 8'h5A;
        status_sent = 1'b0;
        rsp_valid = 1'b0;
        rsp_nodata = 1'b0;
        rsp_dir = 16'h0000;
        forever begin
            @(negedge clk_sys);
            pat = {pat[6:0], pat[7] ^ pat[5]};
            rsp_nodata = pat[0];
            rsp_dir = {pat, ~pat};
            if (status_req_q === 1'b1) begin
                repeat (pat[1:0]) @(negedge clk_sys);
                status_sent = 1'b1;
                @(negedge clk_sys);
                status_sent = 1'b0;
                repeat (pat[4:2]) @(negedge clk_sys);
                if (mode != 2'h3) begin
                    rsp_valid = 1'b1;
                    rsp_nodata = (mode == 2'h1);
                    rsp_dir = (mode == 2'h2) ? ~good_dir : good_dir;
                    @(negedge clk_sys);
                    rsp_valid = 1'b0;
                end
            end
        end
    end
endmodule

// [bench/tb_top.sv]
// Self-checking bench of the card presence supervisor with a card model.
// Assumes short query and reply counts so that the run stays brief.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [29:0] ASK = 30'h14;
    localparam logic [29:0] RSP = 30'h0A;
    logic clk_sys, rst, cs_active, pdp_active, xfer_done, dir_sel_valid, card_out;
    logic end_cs_q, end_pd_q, status_req_q, status_sent, rsp_valid, rsp_nodata;
    logic card_gone_q, ecs, epd, req_p, call_p, failed;
    logic [3:0] ctx_id, bearer_id_q, eid;
    logic [15:0] dir_sel, good_dir, rsp_dir;
    logic [1:0] mode;
    logic [31:0] seed;
    int miscompares, n_tests, cyc, q, n_end, t_sent, t_rsp, t_end, base;
    cps_supervisor #(.ASK_CYC(ASK), .RSP_CYC(RSP)) dut (.clk_sys(clk_sys), .rst(rst),
        .cs_active(cs_active), .pdp_active(pdp_active), .ctx_id(ctx_id),
        .end_cs_q(end_cs_q), .end_pd_q(end_pd_q), .bearer_id_q(bearer_id_q),
        .xfer_done(xfer_done), .dir_sel_valid(dir_sel_valid), .dir_sel(dir_sel),
        .status_req_q(status_req_q), .status_sent(status_sent), .rsp_valid(rsp_valid),
        .rsp_nodata(rsp_nodata), .rsp_dir(rsp_dir), .card_out(card_out),
        .card_gone_q(card_gone_q));
    cps_card_model card (.clk_sys(clk_sys), .status_req_q(status_req_q), .mode(mode),
        .good_dir(good_dir), .status_sent(status_sent), .rsp_valid(rsp_valid),
        .rsp_nodata(rsp_nodata), .rsp_dir(rsp_dir));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task report_and_stop;
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Quiet cycles with random exchanges; the strobe is dropped at the end.
    task idle(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            seed = xs(seed);
            xfer_done = (seed[4:0] == 5'h00);
        end
        @(negedge clk_sys);
        xfer_done = 1'b0;
    endtask
    task sel_dir(input logic [15:0] d);
        @(negedge clk_sys);
        xfer_done = 1'b1;
        dir_sel_valid = 1'b1;
        dir_sel = d;
        good_dir = d;
        @(negedge clk_sys);
        xfer_done = 1'b0;
        dir_sel_valid = 1'b0;
        dir_sel = ~d;
    endtask
    // Bounded wait for one more end pulse.
    task wait_end(input int lim);
        int n0;
        n0 = n_end;
        for (int i = 0; i < lim && n_end == n0; i++) @(negedge clk_sys);
        chk("end pulse count", n0 + 1, n_end);
    endtask
    // ****************************************************************
    // Stimulus and monitor
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Quiet time is counted here from the bench's own view of the interface.
    always @(posedge clk_sys) begin
        cyc++;
        if (status_sent) t_sent = cyc;
        if (rsp_valid) t_rsp = cyc;
        if (end_cs_q | end_pd_q) begin
            n_end++;
            t_end = cyc;
            ecs = end_cs_q;
            epd = end_pd_q;
            eid = bearer_id_q;
            failed = 1'b1;
        end
        if (!(cs_active | pdp_active)) failed = 1'b0;
        if (status_req_q && !req_p && q < ASK - 2) chk("early query", 0, q);
        if (status_req_q && !call_p && !(cs_active | pdp_active))
            chk("query no call", 0, 1);
        if (rst || !(cs_active | pdp_active) || failed || xfer_done || status_sent || rsp_valid
            || status_req_q) q = 0;
        else q++;
        if (q > ASK + 3) chk("quiet cycles", ASK + 3, q);
        req_p = status_req_q;
        call_p = cs_active | pdp_active;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        report_and_stop;
    end
    initial begin
        {cs_active, pdp_active, xfer_done, dir_sel_valid, card_out, failed} = 6'h00;
        {ctx_id, dir_sel, good_dir, mode} = 38'h0;
        seed = 32'h0000000C;
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("reset outputs", 0, {end_cs_q, end_pd_q, status_req_q, card_gone_q, bearer_id_q});
        rst = 1'b0;
        idle(3 * ASK);
        chk("idle query", 0, status_req_q);
        for (int k = 1; k < 4; k++) begin
            for (int m = 1; m < 4; m++) begin
                seed = xs(seed);
                @(negedge clk_sys);
                {pdp_active, cs_active} = k[1:0];
                ctx_id = seed[3:0];
                mode = 2'h0;
                sel_dir(seed[31:16]);
                base = n_end;
                idle(4 * ASK);
                chk("no end in good run", base, n_end);
                @(negedge clk_sys);
                // Nonblocking, since the card model may read the mode on this same edge.
                mode <= m[1:0];
                wait_end(2 * ASK + RSP);
                chk("end circuit", k[0], ecs);
                chk("end bearer", k[1], epd);
                chk("bearer id", ctx_id, eid);
                chk("end delay", 1, (m == 2) ? (t_end - t_rsp <= 3)
                    : (t_end - t_sent <= RSP + 4));
                @(negedge clk_sys);
                {pdp_active, cs_active} = 2'h0;
                idle(3);
            end
        end
        // A pulled card ends the call before any query, with the card model set to answer well.
        @(negedge clk_sys);
        cs_active = 1'b1;
        mode = 2'h0;
        idle(5);
        card_out = 1'b1;
        wait_end(8);
        chk("gone flag", 1, card_gone_q);
        chk("end circuit", 1, ecs);
        card_out = 1'b0;
        cs_active = 1'b0;
        idle(6);
        chk("gone flag", 0, card_gone_q);
        report_and_stop;
    end
endmodule
